// *** design/ccms_clock_mode.sv ***
`timescale 1ns/1ps
`include "ccms_map.svh"
`default_nettype none
module ccms_clock_mode
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  clk_en,
    // Strap pins and configuration
    input  wire logic [2:0]            clock_mode_strap_pins,
    input  wire logic [7:0]            system_config_register,
    // Mode outputs
    output logic [2:0]                 clock_mode_code,
    output ccms_pkg::ccms_mode_e       clock_mode,
    output ccms_pkg::ccms_factor_t     pll_factor,
    output logic                       pll_enable,
    output logic                       pll_free_running,
    output logic                       osc_amp_enable,
    output logic                       ext_clock_accept,
    // CPU clock model
    output logic                       cpu_clk,
    output logic                       cpu_edge,
    output logic                       cpu_rise,
    output logic                       cpu_fall
);
    logic [2:0] strap_meta_reg;
    logic [2:0] strap_sync_reg;
    logic [1:0] owd_sync_reg;
    logic       captured_reg;
    logic       osc_watchdog_disable;
    ccms_pkg::ccms_mode_e mode_next;
    ccms_pkg::ccms_factor_t factor_next;

    assign osc_watchdog_disable = owd_sync_reg[1];

    // Strap sync keeps running in reset, so the capture sees reset-time levels
    always_ff @(posedge clk)
    begin
        if (clk_en)
        begin
            strap_meta_reg <= clock_mode_strap_pins;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            owd_sync_reg <= {2{`CCMS_OWD_DIS_RESET}};
        end
        else if (clk_en)
        begin
            owd_sync_reg <= {owd_sync_reg[0], system_config_register[`CCMS_OWD_DIS_BIT]};
        end
    end

    always_comb
    begin
        factor_next = `CCMS_FACTOR_X4;
        mode_next   = ccms_pkg::CCMS_PLL;
        case (strap_sync_reg)
            `CCMS_STRAP_X4:       factor_next = `CCMS_FACTOR_X4;
            `CCMS_STRAP_X3:       factor_next = `CCMS_FACTOR_X3;
            `CCMS_STRAP_X8:       factor_next = `CCMS_FACTOR_X8;
            `CCMS_STRAP_X5:       factor_next = `CCMS_FACTOR_X5;
            `CCMS_STRAP_DIRECT:
            begin
                factor_next = `CCMS_FACTOR_DIRECT;
                mode_next   = ccms_pkg::CCMS_DIRECT;
            end
            `CCMS_STRAP_X10:      factor_next = `CCMS_FACTOR_X10;
            `CCMS_STRAP_PRESCALE:
            begin
                factor_next = `CCMS_FACTOR_PRESCALE;
                mode_next   = ccms_pkg::CCMS_PRESCALE;
            end
            default:              factor_next = `CCMS_FACTOR_X16;
        endcase
    end

    // Capture on the first enabled edge after release, then freeze
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            captured_reg     <= 1'b0;
            clock_mode_code  <= `CCMS_STRAP_X4;
            clock_mode       <= ccms_pkg::CCMS_PLL;
            pll_factor       <= `CCMS_FACTOR_X4;
        end
        else if (clk_en && !captured_reg)
        begin
            captured_reg    <= 1'b1;
            clock_mode_code <= strap_sync_reg;
            clock_mode      <= mode_next;
            pll_factor      <= factor_next;
        end
    end

    // PLL multiplies in the PLL modes, else runs only as the watchdog clock
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_enable <= 1'b0;
        end
        else if (clk_en && captured_reg)
        begin
            case (clock_mode)
                ccms_pkg::CCMS_DIRECT:
                begin
                    pll_enable <= !osc_watchdog_disable;
                end
                ccms_pkg::CCMS_PRESCALE:
                begin
                    pll_enable <= !osc_watchdog_disable;
                end
                default:
                begin
                    pll_enable <= 1'b1;
                end
            endcase
        end
    end

    // Free-running only while the watchdog needs a clock
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pll_free_running <= 1'b0;
        end
        else if (clk_en && captured_reg)
        begin
            case (clock_mode)
                ccms_pkg::CCMS_DIRECT:
                begin
                    pll_free_running <= !osc_watchdog_disable;
                end
                ccms_pkg::CCMS_PRESCALE:
                begin
                    pll_free_running <= !osc_watchdog_disable;
                end
                default:
                begin
                    pll_free_running <= 1'b0;
                end
            endcase
        end
    end

    // Amplifier bypassed only in direct drive
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            osc_amp_enable <= 1'b1;
        end
        else if (clk_en && captured_reg)
        begin
            case (clock_mode)
                ccms_pkg::CCMS_DIRECT:
                begin
                    osc_amp_enable <= 1'b0;
                end
                default:
                begin
                    osc_amp_enable <= 1'b1;
                end
            endcase
        end
    end

    // A forced input clock is legal only in direct drive
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_clock_accept <= 1'b0;
        end
        else if (clk_en && captured_reg)
        begin
            case (clock_mode)
                ccms_pkg::CCMS_DIRECT:
                begin
                    ext_clock_accept <= 1'b1;
                end
                default:
                begin
                    ext_clock_accept <= 1'b0;
                end
            endcase
        end
    end

    // Prescaler model: clk stands for the input clock, each phase one period
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_clk <= 1'b0;
        end
        else if (clk_en && captured_reg && clock_mode == ccms_pkg::CCMS_PRESCALE)
        begin
            cpu_clk <= !cpu_clk;
        end
    end

    // One pulse per CPU clock edge, rising and falling told apart
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cpu_edge <= 1'b0;
            cpu_rise <= 1'b0;
            cpu_fall <= 1'b0;
        end
        else if (clk_en)
        begin
            cpu_edge <= 1'b0;
            cpu_rise <= 1'b0;
            cpu_fall <= 1'b0;
            if (captured_reg && clock_mode == ccms_pkg::CCMS_PRESCALE)
            begin
                cpu_edge <= 1'b1;
                cpu_rise <= !cpu_clk;
                cpu_fall <= cpu_clk;
            end
        end
    end
endmodule : ccms_clock_mode
`default_nettype wire

// *** design/ccms_map.svh ***
// Notes on behaviour
// - Mode chosen from straps sampled during reset
// - Strap codes map to six multiplier modes plus direct and prescale
// - External forced clock accepted only in direct
// - Code 001 halves input via prescaler
// - Prescaler phases each last one input period
// - Activity triggered on both CPU clock edges
// - Half-period interval is the timing unit
// - Prescaler, watchdog enabled: PLL free-runs
// - Prescaler, watchdog disabled: PLL switched off
// - Watchdog disable is config bit 4, reset enabled
// - Code 011: PLL runs only as watchdog clock, amplifier bypassed, direct
`ifndef CCMS_MAP_SVH
`define CCMS_MAP_SVH

`define CCMS_STRAP_X4        3'h7
`define CCMS_STRAP_X3        3'h6
`define CCMS_STRAP_X8        3'h5
`define CCMS_STRAP_X5        3'h4
`define CCMS_STRAP_DIRECT    3'h3
`define CCMS_STRAP_X10       3'h2
`define CCMS_STRAP_PRESCALE  3'h1
`define CCMS_STRAP_X16       3'h0
`define CCMS_FACTOR_X4       5'h04
`define CCMS_FACTOR_X3       5'h03
`define CCMS_FACTOR_X8       5'h08
`define CCMS_FACTOR_X5       5'h05
`define CCMS_FACTOR_DIRECT   5'h01
`define CCMS_FACTOR_X10      5'h0a
`define CCMS_FACTOR_PRESCALE 5'h00
`define CCMS_FACTOR_X16      5'h10
`define CCMS_OWD_DIS_BIT     4
`define CCMS_OWD_DIS_RESET   1'b0

`endif

// *** design/ccms_pkg.sv ***
package ccms_pkg;
    typedef enum logic [1:0] {CCMS_PLL, CCMS_DIRECT, CCMS_PRESCALE} ccms_mode_e;
    typedef logic [4:0] ccms_factor_t;
endpackage : ccms_pkg

// *** sim/ccms_clock_mode_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccms_clock_mode_assertions
(
    // Clock, reset, configuration
    input wire logic                   clk, resetn,
    input wire logic                   clk_en,
    input wire logic [7:0]             system_config_register,
    // Mode outputs
    input wire logic [2:0]             clock_mode_code,
    input wire ccms_pkg::ccms_mode_e   clock_mode,
    input wire ccms_pkg::ccms_factor_t pll_factor,
    input wire logic                   pll_enable, pll_free_running,
    input wire logic                   osc_amp_enable, ext_clock_accept,
    // CPU clock
    input wire logic                   cpu_clk, cpu_edge, cpu_rise, cpu_fall
);
    localparam logic [4:0] FX [0:7] = '{5'h10, 5'h00, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
    logic [3:0] cnt_reg;
    logic       ok, pre;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Startup settle window
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) cnt_reg <= 4'h0;
        else if (clk_en && cnt_reg != 4'h8) cnt_reg <= cnt_reg + 4'h1;
    assign ok = cnt_reg == 4'h8;
    assign pre = ok && clock_mode == ccms_pkg::CCMS_PRESCALE;
    sequence s_owd(bit v); (pre && clk_en && system_config_register[4] == v) [*4]; endsequence
    AST_HOLD: assert property (ok && $past(ok) |-> $stable(clock_mode_code)) else $error("mode moved");
    AST_FACTOR: assert property (ok |-> pll_factor == FX[clock_mode_code]) else $error("bad factor");
    AST_PRE: assert property (ok |-> pre == (clock_mode_code == 3'h1)) else $error("bad mode");
    AST_EXT: assert property (ok |-> ext_clock_accept == (clock_mode_code == 3'h3)) else $error("ext");
    AST_AMP: assert property (ok |-> osc_amp_enable == (clock_mode_code != 3'h3)) else $error("amp");
    AST_RUN: assert property (s_owd(1'b0) |-> pll_enable && pll_free_running) else $error("pll off");
    AST_OFF: assert property (s_owd(1'b1) |-> !pll_enable && !pll_free_running) else $error("pll on");
    AST_TCL: assert property (pre && $past(pre) && $past(clk_en) |-> cpu_clk != $past(cpu_clk) && cpu_edge) else $error("tcl");
    AST_FREEZE: assert property (ok && $past(ok) && !$past(clk_en) |-> $stable(cpu_clk) && $stable(cpu_edge) && $stable(pll_enable)) else $error("freeze");
    AST_EDGE: assert property (cpu_edge == (cpu_rise || cpu_fall) && !(cpu_rise && cpu_fall)) else $error("edge");
endmodule : ccms_clock_mode_assertions
bind ccms_clock_mode ccms_clock_mode_assertions i_ccms_clock_mode_assertions
(
    .clk(clk),
    .resetn(resetn),
    .clk_en(clk_en),
    .system_config_register(system_config_register),
    .clock_mode_code(clock_mode_code),
    .clock_mode(clock_mode),
    .pll_factor(pll_factor),
    .pll_enable(pll_enable),
    .pll_free_running(pll_free_running),
    .osc_amp_enable(osc_amp_enable),
    .ext_clock_accept(ext_clock_accept),
    .cpu_clk(cpu_clk),
    .cpu_edge(cpu_edge),
    .cpu_rise(cpu_rise),
    .cpu_fall(cpu_fall)
);
`default_nettype wire

// *** sim/ccms_board.sv ***
`timescale 1ns/1ps
`default_nettype none
module ccms_board
(
    input wire logic       osc,
    input wire logic [2:0] strap_set,
    output logic           xtal_clk,
    output logic [2:0]     clock_mode_strap_pins
);
    assign xtal_clk = osc; // Resonator on the amplifier, never forced
    assign clock_mode_strap_pins = strap_set;
endmodule : ccms_board
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                   osc = 1'b0, clk, resetn = 1'b0, clk_en = 1'b1;
    logic [2:0]             strap_set = 3'h7, pins, code;
    logic [7:0]             cfg = 8'h00;
    ccms_pkg::ccms_mode_e   mode;
    ccms_pkg::ccms_factor_t fac;
    logic                   pen, pfr, amp, ext, cclk, ce, cr, cf;
    int                     mismatches = 0, checks_done = 0;
    always #2 osc = ~osc;
    ccms_board i_ccms_board (.osc(osc), .strap_set(strap_set), .xtal_clk(clk),
        .clock_mode_strap_pins(pins));
    ccms_clock_mode i_ccms_clock_mode (.clk(clk), .resetn(resetn), .clk_en(clk_en),
        .clock_mode_strap_pins(pins), .system_config_register(cfg), .clock_mode_code(code),
        .clock_mode(mode), .pll_factor(fac), .pll_enable(pen), .pll_free_running(pfr),
        .osc_amp_enable(amp), .ext_clock_accept(ext), .cpu_clk(cclk), .cpu_edge(ce),
        .cpu_rise(cr), .cpu_fall(cf));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic boot(input logic [2:0] s);
        @(negedge clk);
        resetn = 1'b0;
        strap_set = s;
        repeat (4) @(negedge clk);
        resetn = 1'b1;
        repeat (8) @(negedge clk);
    endtask : boot
    task automatic all_modes;
        logic [4:0] fx [0:7];
        ccms_pkg::ccms_mode_e em;
        fx = '{5'h10, 5'h00, 5'h0a, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
        for (int s = 0; s < 8; s++)
        begin
            boot(3'(s));
            chk(8'(code), 8'(s));
            chk(8'(fac), 8'(fx[s]));
            chk(8'(ext), 8'(s == 3));
            chk(8'(amp), 8'(s != 3));
            em = ccms_pkg::CCMS_PLL;
            if (s == 3)
                em = ccms_pkg::CCMS_DIRECT;
            if (s == 1)
                em = ccms_pkg::CCMS_PRESCALE;
            chk(8'(mode), 8'(em));
            chk(8'({pen, pfr}), 8'({1'b1, s == 1 || s == 3}));
            strap_set = ~3'(s);
            repeat (4) @(negedge clk);
            chk(8'(code), 8'(s));
        end
    endtask : all_modes
    task automatic prescale;
        int t;
        int e;
        logic last;
        int r;
        int f;
        boot(3'h1);
        chk(8'(mode), 8'(ccms_pkg::CCMS_PRESCALE));
        chk(8'({pen, pfr}), 8'h03);
        t = 0;
        e = 0;
        r = 0;
        f = 0;
        last = cclk;
        repeat (8)
        begin
            @(negedge clk);
            t += int'(cclk != last);
            e += int'(ce);
            r += int'(cr);
            f += int'(cf);
            last = cclk;
        end
        chk(8'(t), 8'h08);
        chk(8'(e), 8'h08);
        chk(8'(r), 8'h04);
        chk(8'(f), 8'h04);
        cfg = 8'h10;
        repeat (6) @(negedge clk);
        chk(8'({pen, pfr}), 8'h00);
    endtask : prescale
    task automatic hold_enable;
        logic frozen;
        @(negedge clk);
        clk_en = 1'b0;
        @(negedge clk);
        frozen = cclk;
        repeat (4) @(negedge clk);
        chk(8'(cclk), 8'(frozen));
        chk(8'(code), 8'h01);
        clk_en = 1'b1;
        @(negedge clk);
        chk(8'(cclk), 8'(!frozen));
    endtask : hold_enable
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results
    initial
    begin
        all_modes();
        prescale();
        hold_enable();
        results();
    end
    initial
    begin
        #20000;
        mismatches++;
        results();
    end
endmodule : tb
`default_nettype wire
